// [rhs_pkg.sv]
// Purpose: Shared constants for the root hub status register block.
// Assumes: One 32-bit register, reached at its byte offset on the port.
// Notes: Overview list below names each behaviour kept by the block.
//
// Overview of operation
// [RULE_01] Low half status, high half change bits.
// [RULE_02] Software writes zero to unused bits.
// [RULE_03] Write one to bit 31 clears wake enable.
// [RULE_04] Write one to bit 15 sets wake enable.
// [RULE_05] Enabled wake turns connect change into resume.
// [RULE_06] Overcurrent flag change sets change flag.
// [RULE_07] Write one to bit 17 clears change flag.
// [RULE_08] Bit 16 always reads zero.
// [RULE_09] Ganged mode: bit 16 powers all ports.
// [RULE_10] Individual mode: bit 16 powers unmasked ports.
// [RULE_11] Bit 0 always reads zero.
// [RULE_12] Ganged mode: bit 0 unpowers all ports.
// [RULE_13] Individual mode: bit 0 unpowers unmasked ports.
// [RULE_14] Bit 1 shows global overcurrent condition.
// [RULE_15] Per-port overcurrent: bit 1 reads zero.
// [RULE_16] Mode zero gangs ports, one individual.
// [RULE_17] In individual mode, masked ports ignore global power commands.
// [RULE_18] Same-cycle change and clear keeps flag set.

package rhs_pkg;
  // Register placement and reset value.
  localparam logic [7:0] RHS_OFFSET = 8'h50;
  localparam logic [31:0] RHS_RESET = 32'h00000000;
  // Field positions.
  localparam int RHS_BIT_CLR_WAKE = 31;
  localparam int RHS_BIT_OC_CHANGE = 17;
  localparam int RHS_BIT_SET_POWER = 16;
  localparam int RHS_BIT_WAKE = 15;
  localparam int RHS_BIT_OC = 1;
  localparam int RHS_BIT_CLR_POWER = 0;
  // Default number of downstream ports.
  localparam int RHS_NPORTS = 2;
endpackage : rhs_pkg

// [rhs_oc_if.sv]
// Purpose: Carries the conditioned overcurrent level and its change pulse.
// Assumes: Both ends run on mclk.
// Notes: The source end owns both signals.
`timescale 1ns/1ns
interface rhs_oc_if;
  logic oc_level;
  logic oc_change;
  modport src (output oc_level, output oc_change);
  modport dst (input oc_level, input oc_change);
endinterface : rhs_oc_if

// [rhs_oc_sync.sv]
// Purpose: Synchronises the overcurrent pin and flags each change of it while per_port_ocp is low.
// Assumes: The pin is asynchronous to mclk; per_port_ocp is a static level.
// Notes: The change pulse lasts one cycle and lines up with the new level.
`timescale 1ns/1ns
module rhs_oc_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic overcurrent_pin,
  input wire logic per_port_ocp,
  rhs_oc_if.src oc
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic chg;
  } rhs_sync_t;

  rhs_sync_t st_q;
  rhs_sync_t st_d;

  // ****************************************************************
  // Synchroniser and change detection
  // ****************************************************************
  // The first stage feeds only the second, so metastability never
  // reaches the level compare.
  always_comb begin
    st_d = st_q;
    st_d.s1 = overcurrent_pin;
    st_d.s2 = st_q.s1;
    st_d.lvl = per_port_ocp ? 1'b0 : st_q.s2; // see [RULE_14] [RULE_15]
    st_d.chg = (st_d.lvl != st_q.lvl); // see [RULE_06]
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign oc.oc_level = st_q.lvl;
  assign oc.oc_change = st_q.chg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  oc_change_pulse_a: assert property ( // see [RULE_06]
    @(posedge mclk) disable iff (!nrst)
    $changed(oc.oc_level) |-> oc.oc_change)
    else $error("Overcurrent change not flagged.");

  oc_perport_zero_a: assert property ( // see [RULE_15]
    @(posedge mclk) disable iff (!nrst)
    per_port_ocp [*2] |-> !oc.oc_level)
    else $error("Overcurrent level shown in per-port mode.");

  oc_pin_follow_a: assert property ( // see [RULE_14]
    @(posedge mclk) disable iff (!nrst)
    (!per_port_ocp && overcurrent_pin) [*4] |-> oc.oc_level)
    else $error("Global overcurrent level not reported.");
endmodule : rhs_oc_sync

// [rhs_status_reg.sv]
// Purpose: Root hub status register with power, wake and overcurrent logic.
// Assumes: Register port and all inputs except the pin run on mclk.
// Notes: Power commands leave as one-cycle per-port set and clear pulses.
`timescale 1ns/1ns
module rhs_status_reg #(
  parameter int NPORTS = rhs_pkg::RHS_NPORTS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  input wire logic power_switching_mode,
  input wire logic [NPORTS-1:0] port_power_mask,
  input wire logic per_port_ocp,
  input wire logic overcurrent_pin,
  input wire logic [NPORTS-1:0] connect_change_flag,
  input wire logic host_suspended_state,
  output logic remote_wake_enable_q,
  output logic overcurrent_change_flag_q,
  output logic global_overcurrent_flag_q,
  output logic [NPORTS-1:0] port_power_set_q,
  output logic [NPORTS-1:0] port_power_clr_q,
  output logic host_resuming_state_q
);
  typedef struct packed {
    logic [31:0] rdata;
    logic wake;
    logic ocic;
    logic global_overcurrent_flag;
    logic [NPORTS-1:0] pwr_set;
    logic [NPORTS-1:0] pwr_clr;
    logic [NPORTS-1:0] csc_prev;
    logic resume;
  } rhs_state_t;

  rhs_state_t st_q;
  rhs_state_t st_d;
  logic hit_wr;
  logic hit_rd;
  logic csc_new;
  logic [NPORTS-1:0] port_sel;

  rhs_oc_if oc ();

  // Overcurrent pin conditioning.
  rhs_oc_sync u_oc (
    .mclk(mclk),
    .nrst(nrst),
    .overcurrent_pin(overcurrent_pin),
    .per_port_ocp(per_port_ocp),
    .oc(oc)
  );

  // ****************************************************************
  // Read word assembly
  // ****************************************************************
  // Status in the low half, change bits in the high half; write-only
  // command bits and unused ranges read as zero.
  function automatic logic [31:0] rhs_read_word(
    input logic ocic,
    input logic wake,
    input logic global_overcurrent_flag
  );
    logic [31:0] w;
    w = rhs_pkg::RHS_RESET;
    w[rhs_pkg::RHS_BIT_OC_CHANGE] = ocic; // see [RULE_01]
    w[rhs_pkg::RHS_BIT_WAKE] = wake; // see [RULE_04]
    w[rhs_pkg::RHS_BIT_OC] = global_overcurrent_flag; // see [RULE_14]
    return w; // see [RULE_08] [RULE_11]
  endfunction : rhs_read_word

  // Address decode and port selection for global power commands.
  assign hit_wr = reg_wr && (reg_addr == rhs_pkg::RHS_OFFSET);
  assign hit_rd = reg_rd && (reg_addr == rhs_pkg::RHS_OFFSET);
  assign csc_new = |(connect_change_flag & ~st_q.csc_prev);
  // Masked ports answer only per-port commands in individual mode.
  assign port_sel = power_switching_mode ? ~port_power_mask // see [RULE_17]
                                         : {NPORTS{1'b1}}; // see [RULE_16]

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Unused write bits are ignored, relying on software writing zeros.
  always_comb begin
    st_d = st_q;
    st_d.pwr_set = '0;
    st_d.pwr_clr = '0;
    st_d.resume = 1'b0;
    st_d.global_overcurrent_flag = oc.oc_level;
    st_d.csc_prev = connect_change_flag;
    if (hit_wr) begin
      // Clear wins when both power commands arrive together.
      if (reg_wdata[rhs_pkg::RHS_BIT_CLR_POWER]) begin
        st_d.pwr_clr = port_sel; // see [RULE_12] [RULE_13]
      end else if (reg_wdata[rhs_pkg::RHS_BIT_SET_POWER]) begin
        st_d.pwr_set = port_sel; // see [RULE_09] [RULE_10]
      end
      if (reg_wdata[rhs_pkg::RHS_BIT_CLR_WAKE]) begin
        st_d.wake = 1'b0; // see [RULE_03]
      end else if (reg_wdata[rhs_pkg::RHS_BIT_WAKE]) begin
        st_d.wake = 1'b1; // see [RULE_04]
      end
      if (reg_wdata[rhs_pkg::RHS_BIT_OC_CHANGE]) begin
        st_d.ocic = 1'b0; // see [RULE_07]
      end
    end
    // Placed after the clear so a same-cycle change is never lost.
    if (oc.oc_change) begin
      st_d.ocic = 1'b1; // see [RULE_06] [RULE_18]
    end
    // Only a newly raised connect change counts, so a held flag does
    // not keep firing resume requests.
    if (st_q.wake && host_suspended_state && csc_new) begin
      st_d.resume = 1'b1; // see [RULE_05]
    end
    if (hit_rd) begin
      st_d.rdata = rhs_read_word(st_q.ocic, st_q.wake, st_q.global_overcurrent_flag);
    end else if (reg_rd) begin
      st_d.rdata = rhs_pkg::RHS_RESET;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs are taken straight from the state register.
  assign reg_rdata_q = st_q.rdata;
  assign remote_wake_enable_q = st_q.wake;
  assign overcurrent_change_flag_q = st_q.ocic;
  assign global_overcurrent_flag_q = st_q.global_overcurrent_flag;
  assign port_power_set_q = st_q.pwr_set;
  assign port_power_clr_q = st_q.pwr_clr;
  assign host_resuming_state_q = st_q.resume;

  // ****************************************************************
  // Checks
  // ****************************************************************
  read_zero_bits_a: assert property ( // see [RULE_08]
    @(posedge mclk) disable iff (!nrst)
    hit_rd |=> (reg_rdata_q[rhs_pkg::RHS_BIT_SET_POWER] == 1'b0)
      && (reg_rdata_q[rhs_pkg::RHS_BIT_CLR_POWER] == 1'b0)
      && (reg_rdata_q[rhs_pkg::RHS_BIT_CLR_WAKE] == 1'b0))
    else $error("Reserved or command bit read as one.");

  read_wake_value_a: assert property ( // see [RULE_04]
    @(posedge mclk) disable iff (!nrst)
    hit_rd |=> reg_rdata_q[rhs_pkg::RHS_BIT_WAKE]
      == $past(remote_wake_enable_q))
    else $error("Wake enable read back wrong.");

  wake_clear_a: assert property ( // see [RULE_03]
    @(posedge mclk) disable iff (!nrst)
    hit_wr && reg_wdata[rhs_pkg::RHS_BIT_CLR_WAKE] |=> !remote_wake_enable_q)
    else $error("Wake enable not cleared.");

  wake_set_a: assert property ( // see [RULE_04]
    @(posedge mclk) disable iff (!nrst)
    hit_wr && reg_wdata[rhs_pkg::RHS_BIT_WAKE]
      && !reg_wdata[rhs_pkg::RHS_BIT_CLR_WAKE] |=> remote_wake_enable_q)
    else $error("Wake enable not set.");

  // The flag must show the change and may only drop after a later clear.
  ocic_set_wins_a: assert property ( // see [RULE_18]
    @(posedge mclk) disable iff (!nrst)
    oc.oc_change |=> overcurrent_change_flag_q ##1
      (overcurrent_change_flag_q
        || $past(hit_wr && reg_wdata[rhs_pkg::RHS_BIT_OC_CHANGE])))
    else $error("Overcurrent change lost.");

  ocic_clear_a: assert property ( // see [RULE_07]
    @(posedge mclk) disable iff (!nrst)
    hit_wr && reg_wdata[rhs_pkg::RHS_BIT_OC_CHANGE] && !oc.oc_change
      |=> !overcurrent_change_flag_q)
    else $error("Change flag not cleared by write one.");

  resume_gate_a: assert property ( // see [RULE_05]
    @(posedge mclk) disable iff (!nrst)
    host_resuming_state_q |-> $past(remote_wake_enable_q)
      && $past(host_suspended_state))
    else $error("Resume raised without wake enable.");

  resume_fire_a: assert property ( // see [RULE_05]
    @(posedge mclk) disable iff (!nrst)
    remote_wake_enable_q && host_suspended_state && csc_new
      |=> host_resuming_state_q)
    else $error("Enabled connect change did not resume.");

  power_gang_a: assert property ( // see [RULE_09]
    @(posedge mclk) disable iff (!nrst)
    hit_wr && !power_switching_mode
      && reg_wdata[rhs_pkg::RHS_BIT_SET_POWER]
      && !reg_wdata[rhs_pkg::RHS_BIT_CLR_POWER]
      |=> port_power_set_q == {NPORTS{1'b1}})
    else $error("Ganged power-on missed a port.");

  power_masked_a: assert property ( // see [RULE_13]
    @(posedge mclk) disable iff (!nrst)
    hit_wr && power_switching_mode
      && reg_wdata[rhs_pkg::RHS_BIT_CLR_POWER]
      |=> port_power_clr_q == ~$past(port_power_mask))
    else $error("Masked port touched by global power-off.");

  oci_read_a: assert property ( // see [RULE_14]
    @(posedge mclk) disable iff (!nrst)
    hit_rd |=> reg_rdata_q[rhs_pkg::RHS_BIT_OC]
      == $past(global_overcurrent_flag_q))
    else $error("Overcurrent bit read back wrong.");

  cover_resume_c: cover property (
    @(posedge mclk) disable iff (!nrst) host_resuming_state_q);
  cover_oc_clear_race_c: cover property (
    @(posedge mclk) disable iff (!nrst)
    oc.oc_change && hit_wr && reg_wdata[rhs_pkg::RHS_BIT_OC_CHANGE]);
  cover_masked_power_c: cover property (
    @(posedge mclk) disable iff (!nrst)
    hit_wr && power_switching_mode && (|port_power_mask)
      && reg_wdata[rhs_pkg::RHS_BIT_SET_POWER]);
endmodule : rhs_status_reg

// [rhs_port_model.sv]
// Purpose: Model of the downstream port power switches.
// Assumes: Power commands arrive as one-cycle per-port pulses on mclk.
// Notes: Clear is applied after set, so an overlap leaves a port off.
`timescale 1ns/1ns
module rhs_port_model #(
  parameter int NPORTS = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [NPORTS-1:0] power_set,
  input wire logic [NPORTS-1:0] power_clr,
  output logic [NPORTS-1:0] powered_q
);
  // Each switch keeps the last command it saw and is off after reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      powered_q <= '0;
    end else begin
      powered_q <= (powered_q | power_set) & ~power_clr;
    end
  end
endmodule : rhs_port_model

// [tb_rhs_status_reg.sv]
// Purpose: Self-checking bench for the root hub status register.
// Assumes: Inputs change on the falling edge of mclk.
// Notes: A read result is checked at the falling edge after it lands.
`timescale 1ns/1ns
module tb_rhs_status_reg;
  // ****************************************
  // Stimulus signals and the design
  // ****************************************
  logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, adr = rhs_pkg::RHS_OFFSET;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata_q;
  logic mode = 1'b0, ocp = 1'b0, pin = 1'b0, susp = 1'b0;
  logic [1:0] mask = 2'h0, ccf = 2'h0, set_q, clr_q, pow_q;
  logic wake_q, occ_q, oci_q, res_q;
  int miscompares = 0, checks = 0;
  rhs_status_reg #(.NPORTS(2)) i_dut (.mclk(mclk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .power_switching_mode(mode), .port_power_mask(mask),
    .per_port_ocp(ocp), .overcurrent_pin(pin),
    .connect_change_flag(ccf), .host_suspended_state(susp),
    .remote_wake_enable_q(wake_q), .overcurrent_change_flag_q(occ_q),
    .global_overcurrent_flag_q(oci_q), .port_power_set_q(set_q),
    .port_power_clr_q(clr_q), .host_resuming_state_q(res_q));
  rhs_port_model #(.NPORTS(2)) i_ports (.mclk(mclk), .nrst(nrst),
    .power_set(set_q), .power_clr(clr_q), .powered_q(pow_q));
  // Free-running 250 MHz clock.
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write strobe; callers leave every unused bit zero.
  task automatic wr(input logic [31:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = adr;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = adr;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata_q, exp);
  endtask : rd
  // A power command, its one-cycle pulses and the switch state after it.
  task automatic pw(input logic [31:0] d, input logic [1:0] es,
                    input logic [1:0] ec, input logic [1:0] ep);
    wr(d);
    chk(set_q, es);
    chk(clr_q, ec);
    @(negedge mclk);
    chk({set_q, clr_q}, 4'h0);
    chk(pow_q, ep);
  endtask : pw
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    rd(32'h00000000);
    $display("test reset done");
    wr(32'h00008000);
    chk(wake_q, 1'b1);
    wr(32'h00000000);
    rd(32'h00008000);
    wr(32'h80000000);
    chk(wake_q, 1'b0);
    wr(32'h00008000);
    wr(32'h80008000);
    chk(wake_q, 1'b0);
    adr = 8'h4C;
    wr(32'h00008000);
    rd(32'h00000000);
    adr = rhs_pkg::RHS_OFFSET;
    chk(wake_q, 1'b0);
    $display("test wake enable done");
    susp = 1'b1;
    ccf = 2'h2;
    @(negedge mclk);
    chk(res_q, 1'b0);
    wr(32'h00008000);
    ccf = 2'h3;
    @(negedge mclk);
    chk(res_q, 1'b1);
    @(negedge mclk);
    chk(res_q, 1'b0);
    ccf = 2'h0;
    $display("test resume done");
    mask = 2'h1;
    pw(32'h00010000, 2'h3, 2'h0, 2'h3);
    rd(32'h00008000);
    // A read of a neighbouring address must not leave old data behind.
    adr = 8'h4C;
    rd(32'h00000000);
    adr = rhs_pkg::RHS_OFFSET;
    // Both power commands in one write: power-off wins.
    pw(32'h00010001, 2'h0, 2'h3, 2'h0);
    pw(32'h00000001, 2'h0, 2'h3, 2'h0);
    mode = 1'b1;
    pw(32'h00010000, 2'h2, 2'h0, 2'h2);
    pw(32'h00000001, 2'h0, 2'h2, 2'h0);
    pw(32'h00000000, 2'h0, 2'h0, 2'h0);
    $display("test power done");
    wr(32'h80000000);
    pin = 1'b1;
    repeat (6) @(negedge mclk);
    chk({oci_q, occ_q}, 2'h3);
    rd(32'h00020002);
    wr(32'h00000000);
    chk(occ_q, 1'b1);
    wr(32'h00020000);
    chk(occ_q, 1'b0);
    // The pin edge needs two sync stages and the level stage before its
    // change pulse meets the register, so the clear strobe is placed on
    // the fourth rising edge after the pin falls.
    @(negedge mclk);
    pin = 1'b0;
    repeat (2) @(negedge mclk);
    wr(32'h00020000);
    chk(occ_q, 1'b1);
    rd(32'h00020000);
    wr(32'h00020000);
    ocp = 1'b1;
    pin = 1'b1;
    repeat (6) @(negedge mclk);
    rd(32'h00000000);
    $display("test overcurrent done");
    finish_test();
  end
endmodule : tb_rhs_status_reg
